// File: common/event_timer_pkg.sv
package event_timer_pkg;

  // host bus word and address layout
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam logic [3:0] IO_PAGE_TAG = 4'hf;       // upper i/o page, bits 15:12
  localparam int ADDR_SW_LSB = 2;                  // switches decode address bits 11:2
  localparam int ADDR_SW_W = 10;
  localparam int ADDR_LOW_SW_W = 6;                // low pack: bits 7:2
  localparam int VEC_SW_W = 6;                     // vector bits 8:3
  localparam int VEC_W = 9;
  localparam logic [VEC_W-1:0] CAPTURE_VEC_OFFSET = 9'h004;

  // word offsets within the device window, bit 1 of the address
  localparam logic CTRL_WORD = 1'b0;
  localparam logic BPR_WORD = 1'b1;

  // interrupt status and mask registers
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 16'hf3f0;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 16'hf3f2;
  localparam int IRQ_W = 3;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CAP_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // control register field positions
  localparam int GO_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int RATE_LSB = 3;
  localparam int OVF_IE_BIT = 6;
  localparam int OVF_FLAG_BIT = 7;
  localparam int MAINT_T1_BIT = 8;
  localparam int MAINT_T2_BIT = 9;
  localparam int MAINT_OSC_BIT = 10;
  localparam int OSC_OFF_BIT = 11;
  localparam int OVERRUN_BIT = 12;
  localparam int T2_GO_EN_BIT = 13;
  localparam int CAP_IE_BIT = 14;
  localparam int T2_FLAG_BIT = 15;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BPR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_REPEAT, MODE_EVENT, MODE_EVENT_ZERO
  } mode_type;

  // rate select codes: off, five decades, first trigger, line event
  typedef enum logic [2:0] {
    RATE_OFF, RATE_1MHZ, RATE_100KHZ, RATE_10KHZ, RATE_1KHZ, RATE_100HZ,
    RATE_TRIG1, RATE_LINE
  } rate_type;

  // base rate of the prescaler chain
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BASE_PERIOD_NS = 1000;
  localparam int BASE_DIV_CYCLES = (BASE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int DECADE = 10;
  localparam int DECADE_STAGES = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

  typedef struct packed {
    logic     t2Flag;
    logic     capIrqEn;
    logic     t2GoEn;
    logic     overrun;
    logic     oscOff;
    logic     ovfFlag;
    logic     ovfIrqEn;
    rate_type rate;
    mode_type mode;
    logic     go;
  } ctrl_type;

endpackage : event_timer_pkg

// File: design/trigger_edge.sv
`timescale 1ns/1ps
`default_nettype none

module trigger_edge
  import event_timer_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic level,
  input  wire logic risingSel,
  output logic      fire
);

  logic prevLevel;
  logic primed;

  // one level of history is enough: inputs arrive synchronous
  // primed holds off a false edge when the pin idles high after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevLevel <= 1'b0;
      primed <= 1'b0;
    end else if (ce) begin
      prevLevel <= level;
      primed <= 1'b1;
    end
  end

  // slope select: low picks falling edge, high picks rising edge
  assign fire = ce & primed & (risingSel ? (level & ~prevLevel) : (~level & prevLevel));

endmodule // trigger_edge

`default_nettype wire

// File: design/programmable_event_timer.sv
// Function
// R1: run bit clears counter, counts selected source (code clears it only in event modes; single and repeat load the buffer preset)
// R2: second trigger copies count, sets flag
// R3: capture enable set means capture interrupt
// R4: event modes wrap through overflow, keep counting
// R5: overflow sets flag, interrupts when enabled
// R6: event modes count until software clears run
// R7: zero-base mode clears counter after capture
// R8: base address decoded from switches, upper page
// R9: switch on decodes one, off zero
// R10: switch-selected overflow vector, steps of eight
// R11: capture vector equals base vector plus four
// R12: slope switch picks falling or rising edge
// R13: drive overflow and first-trigger pulse outputs
// R14: overflow request wins over simultaneous capture
// R15: overflow with flag still set flags overrun
// R16: counter and buffer preset are sixteen bits
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module programmable_event_timer
  import event_timer_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire bus_req_type              busReq,
  output logic        [DATA_W-1:0]      rdata,
  input  wire logic   [ADDR_LOW_SW_W-1:0] addressSwitchesLow,
  input  wire logic   [9:0]             addressVectorSwitches,
  input  wire logic   [1:0]             triggerSetupSwitches,
  input  wire logic                     firstTriggerInput,
  input  wire logic                     secondTriggerInput,
  input  wire logic                     lineEvent,
  output logic                          overflowPulseOut,
  output logic                          firstTriggerPulseOut,
  output logic                          irq,
  output logic        [VEC_W-1:0]       irqVector
);

  if (CNT_W != DATA_W) begin : g_width_check
    $error("counter width must equal the bus word width");
  end

  ctrl_type             control;
  ctrl_type             next_control;
  logic [CNT_W-1:0]     count;
  logic [CNT_W-1:0]     next_count;
  logic [CNT_W-1:0]     bufferPreset;
  logic [IRQ_W-1:0]     irqStatus;
  logic [IRQ_W-1:0]     irqMask;
  logic                 ovfReqPrev;
  logic                 capReqPrev;

  // address decode from switches
  wire [ADDR_SW_W-1:0] devAddr = {addressVectorSwitches[3:0], addressSwitchesLow}; // R9
  wire inWindow = (busReq.addr[ADDR_W-1:12] == IO_PAGE_TAG)
                & (busReq.addr[11:ADDR_SW_LSB] == devAddr); // R8
  wire selCtrl = inWindow & (busReq.addr[1] == CTRL_WORD);
  wire selBpr = inWindow & (busReq.addr[1] == BPR_WORD);
  wire selStat = (busReq.addr[ADDR_W-1:1] == IRQ_STATUS_ADDR[ADDR_W-1:1]);
  wire selMask = (busReq.addr[ADDR_W-1:1] == IRQ_MASK_ADDR[ADDR_W-1:1]);
  wire wrCtrl = busReq.wr & selCtrl;
  wire wrBpr = busReq.wr & selBpr;
  wire rdStat = busReq.rd & selStat;
  wire [DATA_W-1:0] wd = busReq.wdata;

  // trigger edges; slope switches per input
  logic fire1;
  logic fire2;

  trigger_edge u_trig1 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .level     (firstTriggerInput),
    .risingSel (triggerSetupSwitches[0]),
    .fire      (fire1)
  );

  trigger_edge u_trig2 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .level     (secondTriggerInput),
    .risingSel (triggerSetupSwitches[1]),
    .fire      (fire2)
  );

  // maintenance bits act only as one-shot writes
  wire maintT1 = wrCtrl & wd[MAINT_T1_BIT];
  wire maintT2 = wrCtrl & wd[MAINT_T2_BIT];
  wire maintOsc = wrCtrl & wd[MAINT_OSC_BIT];
  wire trig1 = fire1 | maintT1; // R12
  wire trig2Raw = fire2 | maintT2; // R12

  // prescaler: base rate then a chain of decades
  logic [7:0] baseCnt;
  logic [3:0] decCnt [DECADE_STAGES];
  logic [DECADE_STAGES:0] decTick;
  assign decTick[0] = ce & (baseCnt == 8'(BASE_DIV_CYCLES - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseCnt <= 8'h00;
    end else if (ce) begin
      baseCnt <= decTick[0] ? 8'h00 : baseCnt + 8'h01;
    end
  end

  for (genvar i = 0; i < DECADE_STAGES; i++) begin : g_decade
    assign decTick[i+1] = decTick[i] & (decCnt[i] == 4'(DECADE - 1));
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        decCnt[i] <= 4'h0;
      end else if (decTick[i]) begin
        decCnt[i] <= decTick[i+1] ? 4'h0 : decCnt[i] + 4'h1;
      end
    end
  end

  // source select; internal rates stop when the oscillator is disabled
  logic rateTick;
  always_comb begin
    unique case (control.rate)
      RATE_OFF:    rateTick = 1'b0;
      RATE_1MHZ:   rateTick = decTick[0] & ~control.oscOff;
      RATE_100KHZ: rateTick = decTick[1] & ~control.oscOff;
      RATE_10KHZ:  rateTick = decTick[2] & ~control.oscOff;
      RATE_1KHZ:   rateTick = decTick[3] & ~control.oscOff;
      RATE_100HZ:  rateTick = decTick[4] & ~control.oscOff;
      RATE_TRIG1:  rateTick = trig1;
      RATE_LINE:   rateTick = ce & lineEvent;
    endcase
  end
  wire oscStep = maintOsc & control.oscOff & (control.rate != RATE_OFF)
               & (control.rate != RATE_TRIG1) & (control.rate != RATE_LINE);
  wire tick = rateTick | oscStep;

  // counting events
  wire eventMode = (control.mode == MODE_EVENT) | (control.mode == MODE_EVENT_ZERO);
  wire counting = control.go;
  wire overflow = counting & tick & (count == {CNT_W{1'b1}});
  wire trig2 = trig2Raw & (control.go | control.t2GoEn);
  wire capture = trig2 & control.go & eventMode; // R2

  // next control state; hardware set wins over software clear
  always_comb begin
    next_control = control;
    if (wrCtrl) begin
      next_control.go = wd[GO_BIT];
      next_control.mode = mode_type'(wd[MODE_LSB +: 2]);
      next_control.rate = rate_type'(wd[RATE_LSB +: 3]);
      next_control.ovfIrqEn = wd[OVF_IE_BIT];
      next_control.oscOff = wd[OSC_OFF_BIT];
      next_control.t2GoEn = wd[T2_GO_EN_BIT];
      next_control.capIrqEn = wd[CAP_IE_BIT];
      next_control.overrun = wd[OVERRUN_BIT];
      next_control.ovfFlag = control.ovfFlag & wd[OVF_FLAG_BIT];
      next_control.t2Flag = control.t2Flag & wd[T2_FLAG_BIT];
    end
    // external start: flag assertion sets the run bit once
    if (trig2 & control.t2GoEn) begin
      next_control.go = 1'b1;
      next_control.t2GoEn = 1'b0;
    end
    // rising run bit clears flags; trigger-started run keeps the capture flag
    if (next_control.go & ~control.go) begin
      next_control.ovfFlag = 1'b0;
      next_control.overrun = 1'b0;
      next_control.t2GoEn = 1'b0;
      if (!control.t2GoEn) begin
        next_control.t2Flag = 1'b0;
      end
    end
    if (overflow) begin
      next_control.ovfFlag = 1'b1; // R5
      if (control.ovfFlag) begin
        next_control.overrun = 1'b1; // R15
      end
      if (control.mode == MODE_SINGLE) begin
        next_control.go = 1'b0;
      end
    end
    if (trig2) begin
      next_control.t2Flag = 1'b1; // R2
      if (control.t2Flag) begin
        next_control.overrun = 1'b1;
      end
    end
  end

  // next counter value; the mode written beside the run bit decides clear or load
  wire goRise = next_control.go & ~control.go;
  wire nextEvent = (next_control.mode == MODE_EVENT) | (next_control.mode == MODE_EVENT_ZERO);
  always_comb begin
    next_count = count;
    if (goRise) begin
      next_count = nextEvent ? {CNT_W{1'b0}} : bufferPreset; // R1
    end else if (capture & (control.mode == MODE_EVENT_ZERO)) begin
      next_count = {CNT_W{1'b0}}; // R7
    end else if (overflow & (control.mode == MODE_REPEAT)) begin
      next_count = bufferPreset;
    end else if (counting & tick) begin
      next_count = count + {{(CNT_W-1){1'b0}}, 1'b1}; // R4 R6
    end
  end

  // run bit cleared only by software in event modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control <= ctrl_type'(CTRL_RESET[$bits(ctrl_type)-1:0]);
      count <= {CNT_W{1'b0}};
    end else if (ce) begin
      control <= next_control; // R6
      count <= next_count; // R16
    end
  end

  // buffer preset: software load, or capture of the running count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufferPreset <= BPR_RESET;
    end else if (ce) begin
      if (capture) begin
        bufferPreset <= count; // R2
      end else if (wrBpr) begin
        bufferPreset <= wd;
      end
    end
  end

  // pulse outputs, one cycle each, handy for starting a converter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflowPulseOut <= 1'b0;
      firstTriggerPulseOut <= 1'b0;
    end else if (ce) begin
      overflowPulseOut <= overflow; // R13
      firstTriggerPulseOut <= trig1; // R13
    end
  end

  // interrupt requests and vector
  wire ovfReq = control.ovfFlag & control.ovfIrqEn; // R5
  wire capReq = control.t2Flag & control.capIrqEn; // R3
  wire [VEC_W-1:0] baseVec = {addressVectorSwitches[9:4], 3'b000}; // R10
  assign irqVector = ovfReq ? baseVec : baseVec + CAPTURE_VEC_OFFSET; // R11 R14
  wire [IRQ_W-1:0] irqEvents;
  assign irqEvents[IRQ_OVF_BIT] = ovfReq & ~ovfReqPrev;
  assign irqEvents[IRQ_CAP_BIT] = capReq & ~capReqPrev;
  assign irqEvents[IRQ_OVR_BIT] = next_control.overrun & ~control.overrun;

  // sticky status cleared by its read; a new event in that cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= {IRQ_W{1'b0}};
      irqMask <= IRQ_MASK_RESET;
      ovfReqPrev <= 1'b0;
      capReqPrev <= 1'b0;
    end else if (ce) begin
      ovfReqPrev <= ovfReq;
      capReqPrev <= capReq;
      irqStatus <= (rdStat ? {IRQ_W{1'b0}} : irqStatus) | irqEvents;
      if (busReq.wr & selMask) begin
        irqMask <= wd[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStatus & irqMask);

  // read mux; maintenance bits always read zero, unmapped reads zero
  wire [DATA_W-1:0] ctrlWord = {control.t2Flag, control.capIrqEn, control.t2GoEn,
                                control.overrun, control.oscOff, 3'b000,
                                control.ovfFlag, control.ovfIrqEn, control.rate,
                                control.mode, control.go};
  wire [DATA_W-1:0] readMux = selCtrl ? ctrlWord
                            : selBpr  ? bufferPreset
                            : selStat ? {{(DATA_W-IRQ_W){1'b0}}, irqStatus}
                            : selMask ? {{(DATA_W-IRQ_W){1'b0}}, irqMask}
                            : {DATA_W{1'b0}};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= {DATA_W{1'b0}};
    end else if (ce) begin
      rdata <= busReq.rd ? readMux : {DATA_W{1'b0}};
    end
  end

  // checks
  start_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && goRise && nextEvent |=> count == '0) // R1
    else $error("event run did not start from zero");

  capture_copy_a: assert property (@(posedge clk) disable iff (rst)
    ce && capture |=> bufferPreset == $past(count) && control.t2Flag) // R2
    else $error("capture did not copy count or set flag");

  capture_irq_a: assert property (@(posedge clk) disable iff (rst)
    ce && capture && control.capIrqEn && irqMask[IRQ_CAP_BIT] && !rdStat
    && !wrCtrl |=> ##1 irq) // R3
    else $error("capture interrupt missing");

  wrap_a: assert property (@(posedge clk) disable iff (rst)
    ce && overflow && eventMode && !capture && !wrCtrl
    |=> count == '0 && control.go) // R4
    else $error("event mode did not wrap");

  overflow_flag_a: assert property (@(posedge clk) disable iff (rst)
    ce && overflow |=> control.ovfFlag) // R5
    else $error("overflow flag not set");

  keep_run_a: assert property (@(posedge clk) disable iff (rst)
    ce && control.go && eventMode && !wrCtrl |=> control.go) // R6
    else $error("event mode stopped without software");

  zero_base_a: assert property (@(posedge clk) disable iff (rst)
    ce && capture && control.mode == MODE_EVENT_ZERO && !goRise |=> count == '0) // R7
    else $error("zero base did not clear after capture");

  vector_pick_a: assert property (@(posedge clk) disable iff (rst)
    capReq && !ovfReq |-> irqVector == baseVec + CAPTURE_VEC_OFFSET) // R11
    else $error("capture vector wrong");

  vector_priority_a: assert property (@(posedge clk) disable iff (rst)
    ovfReq && capReq |-> irqVector == baseVec) // R14
    else $error("overflow did not take priority");

  overrun_a: assert property (@(posedge clk) disable iff (rst)
    ce && overflow && control.ovfFlag |=> control.overrun) // R15
    else $error("overrun not reported");

  pulse_out_a: assert property (@(posedge clk) disable iff (rst)
    ce && overflow |=> overflowPulseOut) // R13
    else $error("overflow pulse missing");

endmodule // programmable_event_timer

`default_nettype wire

// File: dv/trigger_source.sv
`timescale 1ns/1ps
`default_nettype none

// far-side trigger conditioner: a clean level that flips once per kick,
// the way a hysteresis stage only fires again after crossing back
module trigger_source (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic kick,
  output logic      level
);
  // idle low after reset, matching the edge history of the block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else if (kick) begin
      level <= ~level;
    end
  end
endmodule // trigger_source

`default_nettype wire

// File: dv/programmable_event_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin nFail++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end

module programmable_event_timer_tb_top
  import event_timer_pkg::*;
;
  localparam logic [15:0] BASE = 16'hf110;
  localparam logic [8:0]  VEC  = 9'h120;
  typedef struct packed {logic [15:0] val; logic [15:0] msk;} note_type;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        lineEvent = 1'b0;
  logic [1:0]  kick = 2'b00;
  wire logic   trig1;
  wire logic   trig2;
  bus_req_type busReq = '0;
  logic [5:0]  swLow = 6'h04;
  logic [9:0]  swVec = {6'h24, 4'h1};
  logic [1:0]  slope = 2'b11;
  logic [15:0] rdata;
  logic        ovfPulse;
  logic        t1Pulse;
  logic        irq;
  logic [8:0]  irqVector;
  note_type    notes[$];
  note_type    nt;
  logic        rdPend = 1'b0;
  int          nFail = 0;
  int          checked = 0;
  int          cycles = 0;
  int          nOvf = 0;
  int          nPulse1 = 0;
  int          n;
  int          k;
  int          m;
  logic [31:0] rnd = 32'hdf5e238a;
  logic [15:0] base;

  always #4 clk = ~clk;

  programmable_event_timer dut_u (
    .clk(clk), .rst(rst), .ce(ce), .busReq(busReq), .rdata(rdata),
    .addressSwitchesLow(swLow), .addressVectorSwitches(swVec),
    .triggerSetupSwitches(slope), .firstTriggerInput(trig1),
    .secondTriggerInput(trig2), .lineEvent(lineEvent),
    .overflowPulseOut(ovfPulse), .firstTriggerPulseOut(t1Pulse),
    .irq(irq), .irqVector(irqVector)
  );

  trigger_source trigA_u (.clk(clk), .rst(rst), .kick(kick[0]), .level(trig1));
  trigger_source trigB_u (.clk(clk), .rst(rst), .kick(kick[1]), .level(trig2));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    if (nFail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // bus strobes last one cycle; release lands on an edge, next op waits one more
  task automatic busWrite(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) busReq <= '0;
  endtask

  task automatic busRead(input logic [15:0] a, input logic [15:0] v, input logic [15:0] mk);
    notes.push_back('{val: v & mk, msk: mk});
    @(posedge clk) busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) busReq <= '0;
  endtask

  // one edge on a trigger line, then room for the registered pulse to land
  task automatic toggle(input int i);
    @(posedge clk) kick[i] <= 1'b1;
    @(posedge clk) kick[i] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic pulse(input int i);
    toggle(i);
    toggle(i);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rdPend <= busReq.rd;
  always @(negedge clk) begin
    if (rdPend) begin
      nt = notes.pop_front();
      `CHK("rdata", nt.val, rdata & nt.msk)
    end
  end

  // pulse counters and the hang guard
  always @(posedge clk) begin
    if (ovfPulse === 1'b1) nOvf <= nOvf + 1;
    if (t1Pulse === 1'b1) nPulse1 <= nPulse1 + 1;
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      nFail++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values, an unmapped hole, then open all interrupt sources
    busRead(BASE, 16'h0000, 16'hffff);
    busRead(BASE + 16'h2, 16'h0000, 16'hffff);
    busRead(16'hf3f2, 16'h0000, 16'hffff);
    busRead(BASE + 16'h4, 16'h0000, 16'hffff);
    `CHK("irq", 1'b0, irq)
    busWrite(16'hf3f2, 16'h0007);
    // slope choice decides which edge of trigger one fires
    for (k = 0; k < 2; k++) begin
      slope <= {k[0], k[0]};
      n = nPulse1;
      toggle(0);
      `CHK("t1 pulses", n + k, nPulse1)
      toggle(0);
      `CHK("t1 pulses", n + 1, nPulse1)
    end
    // capture in event mode and zero-base mode, counting trigger one
    for (m = 2; m < 4; m++) begin
      busWrite(BASE, 16'h0000);
      busWrite(BASE, (m == 2) ? 16'h4035 : 16'h4037);
      repeat (3) pulse(0);
      pulse(1);
      `CHK("irq", 1'b1, irq)
      `CHK("vector", VEC + 9'h004, irqVector)
      busRead(BASE + 16'h2, 16'h0003, 16'hffff);
      busRead(BASE, (m == 2) ? 16'hc035 : 16'hc037, 16'hffff);
      repeat (2) pulse(0);
      pulse(1);
      busRead(BASE + 16'h2, (m == 2) ? 16'h0005 : 16'h0002, 16'hffff);
      busRead(16'hf3f0, 16'h0002, 16'h0002);
    end
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    // repeat mode from a short preset: two overflows before software looks
    busWrite(BASE, 16'h0000);
    busWrite(BASE + 16'h2, 16'hfff0);
    // clock enable low freezes the block: this write must not land
    ce <= 1'b0;
    busWrite(BASE + 16'h2, 16'h1234);
    ce <= 1'b1;
    busRead(BASE + 16'h2, 16'hfff0, 16'hffff);
    busWrite(BASE, 16'h007b);
    lineEvent <= 1'b1;
    repeat (40) @(posedge clk);
    lineEvent <= 1'b0;
    busRead(BASE, 16'h1081, 16'h1081);
    busRead(16'hf3f0, 16'h0005, 16'h0005);
    // event mode wraps after 65536 ticks with a capture already pending
    busWrite(BASE, 16'h0000);
    busWrite(BASE, 16'h407d);
    pulse(1);
    `CHK("vector", VEC + 9'h004, irqVector)
    n = nOvf;
    k = 0;
    lineEvent <= 1'b1;
    while (nOvf == n && k < 70000) begin
      @(posedge clk);
      k++;
    end
    lineEvent <= 1'b0;
    `CHK("overflows", n + 1, nOvf)
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    `CHK("vector", VEC, irqVector)
    pulse(1);
    busRead(BASE + 16'h2, 16'h0000, 16'hfff0);
    busRead(BASE, 16'h0081, 16'h0081);
    // single mode stepped by the maintenance bit with the oscillator off
    busWrite(BASE, 16'h0000);
    busWrite(BASE + 16'h2, 16'hffff);
    busWrite(BASE, 16'h0809);
    n = nOvf;
    busWrite(BASE, 16'h0c09);
    repeat (3) @(posedge clk);
    `CHK("overflows", n + 1, nOvf)
    busRead(BASE, 16'h0888, 16'hffff);
    // start armed on trigger two, then fired by the maintenance trigger
    busWrite(BASE, 16'h2000);
    busWrite(BASE, 16'h2200);
    busRead(BASE, 16'h8001, 16'hffff);
    // random switch settings move the register window and the vector
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      swLow <= rnd[5:0];
      swVec <= rnd[15:6];
      base = {4'hf, rnd[9:6], rnd[5:0], 2'b00};
      busWrite(base, 16'h0040);
      busRead(base, 16'h0040, 16'hffff);
      `CHK("vector", {rnd[15:10], 3'b000}, irqVector & 9'h1f8)
    end
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule // programmable_event_timer_tb_top

`default_nettype wire
